/* design/vpa_defs.svh */
// constants of the voice array page access block
`ifndef VPA_DEFS_SVH
`define VPA_DEFS_SVH
`define VPA_PAGES 1888
`define VPA_PAGE_BITS 2048
`define VPA_BLK_BITS 64
`define VPA_BLKS_PER_PAGE 32
`define VPA_BLKS_PER_SEG 4
`define VPA_SEGS_PER_PAGE 8
`define VPA_SEG_SAMPLES 256
`define VPA_BYTES_PER_BLK 8
`define VPA_LAST_BLK 16'hEBFF
`define VPA_MCLK_NS 5
`define VPA_SMP_8K0_NS 125000
`define VPA_SMP_6K4_NS 156250
`define VPA_SMP_5K3_NS 188679
`define VPA_SMP_4K0_NS 250000
`define VPA_PROG_NS 1000
`define VPA_PROG_CYC ((`VPA_PROG_NS + `VPA_MCLK_NS - 1) / `VPA_MCLK_NS)
`endif

/* design/vpa_pkg.sv */
// types of the voice array page access block
package vpa_pkg;
   typedef enum logic [2:0] {
      VPA_OP_DWRITE = 3'h0,
      VPA_OP_DREAD = 3'h1,
      VPA_OP_REC = 3'h2,
      VPA_OP_PLAY = 3'h3,
      VPA_OP_STOP = 3'h4,
      VPA_OP_RATE = 3'h5,
      VPA_OP_CLRINT = 3'h6
   } vpa_op_e;
   typedef enum logic [1:0] {
      VPA_RATE_8K0 = 2'h0,
      VPA_RATE_6K4 = 2'h1,
      VPA_RATE_5K3 = 2'h2,
      VPA_RATE_4K0 = 2'h3
   } vpa_rate_e;
   typedef enum logic [1:0] {
      VPA_KIND_CMD = 2'h0,
      VPA_KIND_WBYTE = 2'h1,
      VPA_KIND_RBYTE = 2'h2
   } vpa_kind_e;
   typedef enum logic [2:0] {
      VPA_ST_IDLE = 3'h1,
      VPA_ST_REC = 3'h2,
      VPA_ST_PLAY = 3'h4
   } vpa_state_e;
   typedef struct packed {
      vpa_kind_e kind;
      vpa_op_e op;
      logic [10:0] page;
      vpa_rate_e rate;
      logic [7:0] data;
   } vpa_req_s;
endpackage

/* design/vpa_top.sv */
// voice array page access: page store, analog markers, double-buffered digital path
// Notes on behaviour
// - array holds 1888 pages of 2048 bits each
// - analog commands pick a page with an 11-bit page field
// - at 8 kHz one page spans 256 ms of audio
// - digital pages split into thirty-two 64-bit blocks
// - page content type follows the opcode that writes the page
// - analog page has 8 end markers, one after each 4 blocks
// - analog recording end resolves to 32 ms at 8 kHz
// - analog recording starts only on a page boundary
// - recording stop finishes the current 256-sample segment then sets its end marker
// - playback reaching a set end marker raises the interrupt
// - serial write bytes shift into one of two alternating 64-bit registers
// - full input register is written to the array, other takes input
// - write data taken a byte at a time, each byte acknowledged
// - acknowledge held back until buffer space frees; host waits for it
// - reads load a 64-bit register from the array then shift out
// - sampling rate selectable among 4.0, 5.3, 6.4 and 8.0 kHz
// - row timing and interrupt outputs provided beside the serial bus
// - all register and memory access goes through the serial link
`timescale 1ns/1ps
`include "vpa_defs.svh"
module vpa_top
   import vpa_pkg::*;
#(
   parameter int unsigned SMP_8K0_CYC = `VPA_SMP_8K0_NS / `VPA_MCLK_NS,
   parameter int unsigned SMP_6K4_CYC = `VPA_SMP_6K4_NS / `VPA_MCLK_NS,
   parameter int unsigned SMP_5K3_CYC = `VPA_SMP_5K3_NS / `VPA_MCLK_NS,
   parameter int unsigned SMP_4K0_CYC = `VPA_SMP_4K0_NS / `VPA_MCLK_NS
)
(
   input logic mclk,
   input logic rst_n,
   input logic lclk,
   input logic lreq_valid,
   input vpa_req_s lreq,
   output logic lack_r,
   output logic [7:0] lrsp_r,
   output logic row_timing_r,
   output logic irq_r
);
   localparam int PROG_CYC_I = `VPA_PROG_CYC;
   localparam logic [10:0] PAGES = 11'(`VPA_PAGES);
   localparam logic [7:0] SEG_LAST = 8'(`VPA_SEG_SAMPLES - 1);

   // link side: one request in flight, held stable until the core answers
   logic l_busy_r;
   logic l_req_tgl_r;
   vpa_req_s l_req_r;
   logic l_ack_s1_r, l_ack_s2_r, l_ack_s3_r, l_ack_seen_r;
   logic l_ack_evt;
   logic c_ack_tgl_r;
   logic [7:0] c_rsp_r;

   always_ff @(posedge lclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         l_busy_r <= 1'b0;
         l_req_tgl_r <= 1'b0;
         l_req_r <= '0;
      end
      else if (lreq_valid && !l_busy_r)
      begin
         l_req_r <= lreq;
         l_req_tgl_r <= ~l_req_tgl_r;
         l_busy_r <= 1'b1;
      end
      else if (l_ack_evt)
         l_busy_r <= 1'b0;
   end

   always_ff @(posedge lclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         l_ack_s1_r <= 1'b0;
         l_ack_s2_r <= 1'b0;
         l_ack_s3_r <= 1'b0;
         l_ack_seen_r <= 1'b0;
      end
      else
      begin
         l_ack_s1_r <= c_ack_tgl_r;
         l_ack_s2_r <= l_ack_s1_r;
         l_ack_s3_r <= l_ack_s2_r;
         if (l_ack_evt)
            l_ack_seen_r <= l_ack_s3_r;
      end
   end

   assign l_ack_evt = (l_ack_s2_r == l_ack_s3_r) && (l_ack_s3_r != l_ack_seen_r);

   // answer byte is stable in the core until the next request, so sampling it is safe
   always_ff @(posedge lclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lack_r <= 1'b0;
         lrsp_r <= 8'h00;
      end
      else
      begin
         lack_r <= l_ack_evt;
         if (l_ack_evt)
            lrsp_r <= c_rsp_r;
      end
   end

   // core side: request toggle crossing
   logic c_s1_r, c_s2_r, c_s3_r, c_seen_r;
   logic c_evt;
   logic c_pend_r;
   vpa_req_s c_req_r;
   logic wr_ok, rd_ok, cmd_ok, c_done, page_ok;

   assign c_evt = (c_s2_r == c_s3_r) && (c_s3_r != c_seen_r);

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         c_s1_r <= 1'b0;
         c_s2_r <= 1'b0;
         c_s3_r <= 1'b0;
         c_seen_r <= 1'b0;
         c_pend_r <= 1'b0;
         c_req_r <= '0;
         c_ack_tgl_r <= 1'b0;
      end
      else
      begin
         c_s1_r <= l_req_tgl_r;
         c_s2_r <= c_s1_r;
         c_s3_r <= c_s2_r;
         if (c_evt)
         begin
            c_seen_r <= c_s3_r;
            c_req_r <= l_req_r;
            c_pend_r <= 1'b1;
         end
         else if (c_done)
         begin
            c_pend_r <= 1'b0;
            c_ack_tgl_r <= ~c_ack_tgl_r;
         end
      end
   end

   // digital write path state
   logic [63:0] wbuf_r [2];
   logic in_sel_r;
   logic [2:0] wcnt_r;
   logic [1:0] wfull_r;
   logic [15:0] waddr_r;
   logic prog_busy_r, prog_sel_r;
   logic [15:0] prog_addr_r;
   logic [7:0] prog_cnt_r;
   logic prog_start, prog_end;
   // digital read path state
   logic [63:0] rbuf_r [2];
   logic [1:0] rvalid_r;
   logic out_sel_r, load_sel_r, rd_mode_r;
   logic [2:0] rcnt_r;
   logic [15:0] raddr_r;
   // nonvolatile store, no reset
   logic [63:0] mem_r [`VPA_PAGES * `VPA_BLKS_PER_PAGE];
   logic [7:0] eom_r [`VPA_PAGES];
   logic ptype_r [`VPA_PAGES];

   assign page_ok = c_req_r.page < PAGES;
   assign cmd_ok = c_pend_r && (c_req_r.kind == VPA_KIND_CMD);
   assign wr_ok = c_pend_r && (c_req_r.kind == VPA_KIND_WBYTE) && !wfull_r[in_sel_r];
   assign rd_ok = c_pend_r && (c_req_r.kind == VPA_KIND_RBYTE) &&
                  (!rd_mode_r || rvalid_r[out_sel_r]);
   assign c_done = wr_ok || rd_ok || cmd_ok;
   assign prog_start = !prog_busy_r && wfull_r[~in_sel_r];
   assign prog_end = prog_busy_r && (prog_cnt_r == 8'h00);

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         c_rsp_r <= 8'h00;
      else if (c_done)
         c_rsp_r <= (rd_ok && rd_mode_r) ? rbuf_r[out_sel_r][63:56] : 8'h00;
   end

   // write path: two commutating shift registers and the array program engine
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wbuf_r[0] <= 64'h0;
         wbuf_r[1] <= 64'h0;
         in_sel_r <= 1'b0;
         wcnt_r <= 3'h0;
         wfull_r <= 2'h0;
         waddr_r <= 16'h0;
         prog_busy_r <= 1'b0;
         prog_sel_r <= 1'b0;
         prog_addr_r <= 16'h0;
         prog_cnt_r <= 8'h00;
      end
      else
      begin
         if (wr_ok)
         begin
            wbuf_r[in_sel_r] <= {wbuf_r[in_sel_r][55:0], c_req_r.data};
            wcnt_r <= wcnt_r + 3'h1;
            if (wcnt_r == 3'h7)
            begin
               wfull_r[in_sel_r] <= 1'b1;
               in_sel_r <= ~in_sel_r;
            end
         end
         if (prog_end)
         begin
            prog_busy_r <= 1'b0;
            wfull_r[prog_sel_r] <= 1'b0;
         end
         else if (prog_busy_r)
            prog_cnt_r <= prog_cnt_r - 8'h01;
         if (cmd_ok && c_req_r.op == VPA_OP_DWRITE && page_ok)
         begin
            // partial block is dropped: a new write always starts on a block edge
            waddr_r <= {c_req_r.page, 5'h00};
            wcnt_r <= 3'h0;
         end
         else if (prog_start)
         begin
            prog_busy_r <= 1'b1;
            prog_sel_r <= ~in_sel_r;
            prog_addr_r <= waddr_r;
            prog_cnt_r <= 8'(PROG_CYC_I - 1);
            waddr_r <= (waddr_r == `VPA_LAST_BLK) ? 16'h0 : waddr_r + 16'h1;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (prog_end)
         mem_r[prog_addr_r] <= wbuf_r[prog_sel_r];
   end

   // read path: prefetch into the idle register while the other shifts out
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rbuf_r[0] <= 64'h0;
         rbuf_r[1] <= 64'h0;
         rvalid_r <= 2'h0;
         out_sel_r <= 1'b0;
         load_sel_r <= 1'b0;
         rd_mode_r <= 1'b0;
         rcnt_r <= 3'h0;
         raddr_r <= 16'h0;
      end
      else if (cmd_ok && c_req_r.op == VPA_OP_DREAD && page_ok)
      begin
         rd_mode_r <= 1'b1;
         raddr_r <= {c_req_r.page, 5'h00};
         rvalid_r <= 2'h0;
         out_sel_r <= 1'b0;
         load_sel_r <= 1'b0;
         rcnt_r <= 3'h0;
      end
      else if (cmd_ok && (c_req_r.op == VPA_OP_DWRITE || c_req_r.op == VPA_OP_REC))
         rd_mode_r <= 1'b0;
      else
      begin
         if (rd_mode_r && !rvalid_r[load_sel_r])
         begin
            rbuf_r[load_sel_r] <= mem_r[raddr_r];
            rvalid_r[load_sel_r] <= 1'b1;
            load_sel_r <= ~load_sel_r;
            raddr_r <= (raddr_r == `VPA_LAST_BLK) ? 16'h0 : raddr_r + 16'h1;
         end
         if (rd_ok && rd_mode_r)
         begin
            rbuf_r[out_sel_r] <= {rbuf_r[out_sel_r][55:0], 8'h00};
            rcnt_r <= rcnt_r + 3'h1;
            if (rcnt_r == 3'h7)
            begin
               rvalid_r[out_sel_r] <= 1'b0;
               out_sel_r <= ~out_sel_r;
            end
         end
      end
   end

   // analog record and playback sequencing
   vpa_state_e state_r;
   vpa_rate_e rate_r;
   logic [10:0] page_r;
   logic [2:0] seg_r;
   logic [15:0] smp_cnt_r;
   logic [7:0] seg_smp_r;
   logic stop_pend_r;
   logic [15:0] smp_reload;
   logic st_rec, st_play, tick, seg_end, last_seg, rec_stop, play_hit, adv, rec_start;

   always_comb
   begin
      unique case (rate_r)
         VPA_RATE_8K0: smp_reload = 16'(SMP_8K0_CYC - 1);
         VPA_RATE_6K4: smp_reload = 16'(SMP_6K4_CYC - 1);
         VPA_RATE_5K3: smp_reload = 16'(SMP_5K3_CYC - 1);
         VPA_RATE_4K0: smp_reload = 16'(SMP_4K0_CYC - 1);
      endcase
   end

   assign st_rec = state_r == VPA_ST_REC;
   assign st_play = state_r == VPA_ST_PLAY;
   assign tick = smp_cnt_r == 16'h0;
   assign seg_end = (st_rec || st_play) && tick && (seg_smp_r == SEG_LAST);
   assign last_seg = (seg_r == 3'h7) && (page_r == PAGES - 11'h1);
   assign rec_stop = st_rec && seg_end && (stop_pend_r || last_seg);
   assign play_hit = st_play && seg_end && eom_r[page_r][seg_r];
   assign adv = seg_end && !rec_stop && !play_hit && !last_seg;
   assign rec_start = cmd_ok && c_req_r.op == VPA_OP_REC && page_ok;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= VPA_ST_IDLE;
         rate_r <= VPA_RATE_8K0;
         page_r <= 11'h0;
         seg_r <= 3'h0;
         smp_cnt_r <= 16'h0;
         seg_smp_r <= 8'h00;
         stop_pend_r <= 1'b0;
      end
      else if (cmd_ok && (c_req_r.op == VPA_OP_REC || c_req_r.op == VPA_OP_PLAY) && page_ok)
      begin
         state_r <= (c_req_r.op == VPA_OP_REC) ? VPA_ST_REC : VPA_ST_PLAY;
         page_r <= c_req_r.page;
         seg_r <= 3'h0;
         seg_smp_r <= 8'h00;
         smp_cnt_r <= smp_reload;
         stop_pend_r <= 1'b0;
      end
      else
      begin
         if (cmd_ok && c_req_r.op == VPA_OP_RATE)
            rate_r <= c_req_r.rate;
         if (cmd_ok && c_req_r.op == VPA_OP_STOP)
         begin
            // playback stops at once; recording must close its segment first
            if (st_rec)
               stop_pend_r <= 1'b1;
            else
               state_r <= VPA_ST_IDLE;
         end
         if (st_rec || st_play)
         begin
            smp_cnt_r <= tick ? smp_reload : smp_cnt_r - 16'h1;
            if (tick)
               seg_smp_r <= seg_smp_r + 8'h01;
         end
         if (seg_end && !adv)
            state_r <= VPA_ST_IDLE;
         else if (adv)
         begin
            seg_r <= seg_r + 3'h1;
            if (seg_r == 3'h7)
               page_r <= page_r + 11'h1;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rec_start)
      begin
         eom_r[c_req_r.page] <= 8'h00;
         ptype_r[c_req_r.page] <= 1'b0;
      end
      else if (st_rec && adv && seg_r == 3'h7)
      begin
         eom_r[page_r + 11'h1] <= 8'h00;
         ptype_r[page_r + 11'h1] <= 1'b0;
      end
      else if (rec_stop)
         eom_r[page_r][seg_r] <= 1'b1;
      if (prog_start)
         ptype_r[waddr_r[15:5]] <= 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         row_timing_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         row_timing_r <= (st_rec || st_play) && !seg_r[2];
         if (play_hit)
            irq_r <= 1'b1;
         else if (cmd_ok && c_req_r.op == VPA_OP_CLRINT)
            irq_r <= 1'b0;
      end
   end

   a_wr_stall_full: assert property (@(posedge mclk) disable iff (!rst_n)
      (c_pend_r && c_req_r.kind == VPA_KIND_WBYTE && wfull_r[in_sel_r]) |=> c_pend_r)
      else $error("write byte answered while input register full");
   a_fill_swap: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_ok && wcnt_r == 3'h7 && !prog_end) |=> (wfull_r[$past(in_sel_r)] &&
      in_sel_r != $past(in_sel_r)))
      else $error("full input register not swapped");
   a_prog_length: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(prog_busy_r) |-> ##(PROG_CYC_I - 1) prog_end)
      else $error("array program time wrong");
   a_read_swap: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_ok && rd_mode_r && rcnt_r == 3'h7 && !cmd_ok) |=> out_sel_r != $past(out_sel_r))
      else $error("read register not swapped after eight bytes");
   a_rec_start_page: assert property (@(posedge mclk) disable iff (!rst_n)
      rec_start |=> (st_rec && seg_r == 3'h0 && seg_smp_r == 8'h00))
      else $error("recording did not start on a page boundary");
   a_stop_waits: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_rec && stop_pend_r && !seg_end && !cmd_ok) |=> st_rec)
      else $error("recording ended before its segment closed");
   a_eom_irq: assert property (@(posedge mclk) disable iff (!rst_n)
      play_hit |=> (irq_r && state_r == VPA_ST_IDLE))
      else $error("end marker in playback gave no interrupt");
   a_row_timing: assert property (@(posedge mclk) disable iff (!rst_n)
      ((st_rec || st_play) && seg_r == 3'h1) |=> row_timing_r)
      else $error("row timing low in first half of page");
   a_link_one_ack: assert property (@(posedge lclk) disable iff (!rst_n)
      lack_r |=> !lack_r)
      else $error("acknowledge longer than one cycle");
endmodule

/* sim/vpa_host.sv */
// host model: link master that issues one request at a time and waits for its answer
`timescale 1ns/1ps
module vpa_host
   import vpa_pkg::*;
(
   input wire logic lclk,
   input wire logic lack_r,
   input wire logic [7:0] lrsp_r,
   output logic lreq_valid,
   output vpa_req_s lreq
);
   initial
   begin
      lreq_valid = 1'b0;
      lreq = '0;
   end

   // fields held until the answer, then inverted so stale values never look valid
   task automatic xfer(input vpa_kind_e kind, input vpa_op_e op, input logic [10:0] page,
      input vpa_rate_e rate, input logic [7:0] data, output logic [7:0] rsp, output bit ok);
      int n;
      n = 0;
      ok = 1'b0;
      rsp = 8'h00;
      @(negedge lclk);
      lreq_valid = 1'b1;
      lreq = '{kind: kind, op: op, page: page, rate: rate, data: data};
      @(negedge lclk);
      lreq_valid = 1'b0;
      // no next request before the answer or 400 link cycles, stalled or not
      while (!ok && n < 400)
      begin
         @(negedge lclk);
         n++;
         if (lack_r === 1'b1)
         begin
            ok = 1'b1;
            rsp = lrsp_r;
         end
      end
      lreq = ~lreq;
   endtask
endmodule

/* sim/voice_array_page_access_tb.sv */
// testbench of the voice array page access block
`timescale 1ns/1ps
module voice_array_page_access_tb;
   import vpa_pkg::*;
   // shortened sample periods keep a page to 8192 to 16384 core cycles
   localparam int unsigned SMP_CYC [4] = '{4, 5, 6, 8};
   logic mclk;
   logic lclk;
   logic rst_n;
   logic lreq_valid;
   vpa_req_s lreq;
   logic lack_r;
   logic [7:0] lrsp_r;
   logic row_timing_r;
   logic irq_r;
   int err_total;
   int check_count;
   int cycles;

   vpa_top #(
      .SMP_8K0_CYC(SMP_CYC[0]),
      .SMP_6K4_CYC(SMP_CYC[1]),
      .SMP_5K3_CYC(SMP_CYC[2]),
      .SMP_4K0_CYC(SMP_CYC[3])
   ) i_dut (
      .mclk(mclk),
      .rst_n(rst_n),
      .lclk(lclk),
      .lreq_valid(lreq_valid),
      .lreq(lreq),
      .lack_r(lack_r),
      .lrsp_r(lrsp_r),
      .row_timing_r(row_timing_r),
      .irq_r(irq_r)
   );

   vpa_host i_host (
      .lclk(lclk),
      .lack_r(lack_r),
      .lrsp_r(lrsp_r),
      .lreq_valid(lreq_valid),
      .lreq(lreq)
   );

   initial
   begin
      mclk = 1'b0;
      lclk = 1'b0;
   end

   always #2.5 mclk = ~mclk;

   // link clock offset off the 0.5 ns grid so its edges never line up with the core clock
   initial
   begin
      #7.3;
      forever #24 lclk = ~lclk;
   end

   task automatic finish_test();
      if (err_total == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         err_total++;
         finish_test();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic req(input vpa_kind_e k, input vpa_op_e o, input logic [10:0] p,
      input vpa_rate_e rt, input logic [7:0] d, output logic [7:0] r);
      bit ok;
      i_host.xfer(k, o, p, rt, d, r, ok);
      check({7'h00, ok}, 8'h01);
   endtask

   function automatic logic [7:0] pat(input int i);
      return 8'(i * 29 + 53);
   endfunction

   // three blocks written back to back, then read back from the same page
   task automatic test_digital();
      logic [7:0] r;
      int i;
      req(VPA_KIND_RBYTE, VPA_OP_DREAD, 11'h000, VPA_RATE_8K0, 8'h00, r);
      check(r, 8'h00);
      req(VPA_KIND_CMD, VPA_OP_DWRITE, 11'h005, VPA_RATE_8K0, 8'h00, r);
      for (i = 0; i < 24; i++)
      begin
         req(VPA_KIND_WBYTE, VPA_OP_DWRITE, 11'h005, VPA_RATE_8K0, pat(i), r);
         check(r, 8'h00);
      end
      req(VPA_KIND_CMD, VPA_OP_DREAD, 11'h005, VPA_RATE_8K0, 8'h00, r);
      for (i = 0; i < 24; i++)
      begin
         req(VPA_KIND_RBYTE, VPA_OP_DREAD, 11'h005, VPA_RATE_8K0, 8'h00, r);
         check(r, pat(i));
      end
   endtask

   // record, stop in segment 2, then play at every rate and expect the interrupt
   task automatic test_analog();
      logic [7:0] r;
      int i;
      int n;
      req(VPA_KIND_CMD, VPA_OP_RATE, 11'h000, VPA_RATE_8K0, 8'h00, r);
      req(VPA_KIND_CMD, VPA_OP_REC, 11'h00A, VPA_RATE_8K0, 8'h00, r);
      repeat (300) @(negedge mclk);
      check({7'h00, row_timing_r}, 8'h01);
      repeat (2200) @(negedge mclk);
      req(VPA_KIND_CMD, VPA_OP_STOP, 11'h000, VPA_RATE_8K0, 8'h00, r);
      check({7'h00, row_timing_r}, 8'h01);
      repeat (1200) @(negedge mclk);
      check({7'h00, row_timing_r}, 8'h00);
      for (i = 0; i < 4; i++)
      begin
         req(VPA_KIND_CMD, VPA_OP_RATE, 11'h000, vpa_rate_e'(i), 8'h00, r);
         req(VPA_KIND_CMD, VPA_OP_PLAY, 11'h00A, VPA_RATE_8K0, 8'h00, r);
         // marker sits at the end of segment 2: three segments of 256 samples
         n = 768 * SMP_CYC[i];
         repeat (n - 80) @(negedge mclk);
         check({7'h00, irq_r}, 8'h00);
         repeat (160) @(negedge mclk);
         check({7'h00, irq_r}, 8'h01);
         req(VPA_KIND_CMD, VPA_OP_CLRINT, 11'h000, VPA_RATE_8K0, 8'h00, r);
         repeat (4) @(negedge mclk);
         check({7'h00, irq_r}, 8'h00);
      end
   endtask

   initial
   begin
      err_total = 0;
      check_count = 0;
      cycles = 0;
      rst_n = 1'b0;
      // held over several edges of both clocks
      repeat (4) @(negedge lclk);
      @(negedge mclk);
      rst_n = 1'b1;
      repeat (3) @(posedge lclk);
      test_digital();
      test_analog();
      finish_test();
   end
endmodule
